/* File: shared/memory_controller_pkg.sv */
package memory_controller_pkg;

    // ------------------------------------------------------------------
    // Build limits
    // ------------------------------------------------------------------
    localparam int HOST_ADDR_WIDTH = 32;
    localparam int MAX_HOST_DATA_WIDTH = 64;
    localparam int MAX_ID_WIDTH = 16;
    localparam int MAX_BANKS = 4;
    localparam int MAX_STROBE_WIDTH = MAX_HOST_DATA_WIDTH / 8;
    localparam int SYNC_BURST_DATA_WIDTH = 32;
    localparam int STARTUP_DQ_WIDTH = 4;

    // ------------------------------------------------------------------
    // Memory kinds, one per bank
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_SYNC_SRAM = 3'h0,
        KIND_ASYNC_SRAM = 3'h1,
        KIND_LINEAR_FLASH = 3'h2,
        KIND_PAGE_FLASH = 3'h3,
        KIND_PSRAM = 3'h4,
        KIND_BURST_FLASH = 3'h5
    } memory_kind_type;
    localparam int KIND_WIDTH = 3;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the APB port
    // ------------------------------------------------------------------
    localparam int APB_ADDR_WIDTH = 12;
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] TIMING_BASE_OFFSET = 12'h010;
    localparam logic [11:0] TIMING_STRIDE = 12'h004;

    localparam int CTRL_SHIFT_LSB = 0;
    localparam int SHIFT_WIDTH = 2;
    localparam int CTRL_CRE_BIT = 4;
    localparam int CTRL_HOLD_RESET_BIT = 5;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_MASK = 32'h0000_0033;

    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ERROR_BIT = 1;
    localparam int STATUS_BANK_LSB = 4;

    localparam int TIMING_WIDTH = 8;
    localparam logic [7:0] TIMING_RESET = 8'h02;

    // ------------------------------------------------------------------
    // Carriers and sequencer states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [31:0] address;
        logic [63:0] write_data;
        logic [7:0] strobe;
        logic [15:0] id;
    } host_request_type;

    typedef struct packed {
        logic error;
        logic [63:0] read_data;
        logic [15:0] id;
    } host_response_type;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDRESS = 6'h02,
        ST_CHIP = 6'h04,
        ST_STROBE = 6'h08,
        ST_RELEASE = 6'h10,
        ST_FINISH = 6'h20
    } sequence_state_type;

endpackage : memory_controller_pkg

/* File: hdl/bank_window_decoder.sv */
module bank_window_decoder
    import memory_controller_pkg::*;
#(
    parameter int BANKS = 1,
    parameter logic [MAX_BANKS*32-1:0] BANK_BASE = 128'h3000_0000_2000_0000_1000_0000_0000_0000,
    parameter logic [MAX_BANKS*32-1:0] BANK_HIGH = 128'h3fff_ffff_2fff_ffff_1fff_ffff_0fff_ffff
)
(
    // Host address under decode
    input wire logic [31:0] address,
    // Result
    output logic [MAX_BANKS-1:0] bank_hit,
    output logic [1:0] bank_index,
    output logic any_hit
);

    logic [MAX_BANKS-1:0] raw_hit;

    // Only enabled banks can match; a lower bank wins should windows overlap.
    genvar b;
    generate
        for (b = 0; b < MAX_BANKS; b++)
        begin : window
            if (b < BANKS)
            begin : enabled
                assign raw_hit[b] = (address >= BANK_BASE[b*32 +: 32])
                    && (address <= BANK_HIGH[b*32 +: 32]);
            end
            else
            begin : absent
                assign raw_hit[b] = 1'b0;
            end
        end
    endgenerate

    assign bank_index = raw_hit[0] ? 2'h0 : raw_hit[1] ? 2'h1 : raw_hit[2] ? 2'h2 : 2'h3;
    assign any_hit = |raw_hit;
    assign bank_hit = any_hit ? (MAX_BANKS'(1) << bank_index) : '0;

endmodule : bank_window_decoder

/* File: hdl/external_memory_controller.sv */
// Notes on behaviour
// - A 16-bit PSRAM bank uses data 15:0, two low byte enables, high CRE.
// - Every memory pin comes from a flip-flop, CRE and address included; wait is an input.
// - Address changes one cycle apart from chip enable, which leads strobes by one.
// - Startup option moves data 3:0 and chip enable 0 onto the startup port.
// - Host data is 32 bits for synchronous burst flash, else 32 or 64.
// - Host identifier width is a build parameter from 0 to 16.
// - Memory data bus width is 8, 16, 32 or 64, the widest bank.
// - One to four banks, each with its own kind and timing.
// - Each bank has base and high addresses; matching accesses go to it.
// - Each bank is one of six memory kinds.
// - Kind codes: 0 sync SRAM up to 5 burst flash.
//
// Chosen here: the APB interface to the registers and the address map.
module external_memory_controller
    import memory_controller_pkg::*;
#(
    parameter int HOST_DATA_WIDTH = 32,
    parameter int ID_WIDTH = 4,
    parameter int MEM_WIDTH = 32,
    parameter int MEM_ADDR_WIDTH = 32,
    parameter int BANKS = 1,
    parameter logic [MAX_BANKS*32-1:0] BANK_BASE = 128'h3000_0000_2000_0000_1000_0000_0000_0000,
    parameter logic [MAX_BANKS*32-1:0] BANK_HIGH = 128'h3fff_ffff_2fff_ffff_1fff_ffff_0fff_ffff,
    parameter logic [MAX_BANKS*KIND_WIDTH-1:0] BANK_KINDS = 12'h000,
    parameter bit SYNC_BURST = 1'b0,
    parameter bit USE_STARTUP = 1'b0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Host request and answer
    input wire logic host_valid,
    input wire host_request_type host_request,
    output logic host_ready,
    output logic answer_valid,
    output host_response_type answer,
    // Memory pins
    output logic [MEM_ADDR_WIDTH-1:0] mem_address,
    output logic [MAX_BANKS-1:0] mem_chip_enable_n,
    output logic memory_output_enable_n,
    output logic write_enable_n,
    output logic [MEM_WIDTH/8-1:0] lane_write_enable_n,
    output logic [MEM_WIDTH/8-1:0] byte_enable_n,
    output logic memory_reset_powerdown_n,
    output logic config_reg_enable,
    input wire logic mem_wait,
    output logic [MEM_WIDTH-1:0] mem_dq_out,
    output logic [MEM_WIDTH-1:0] mem_dq_oe,
    input wire logic [MEM_WIDTH-1:0] mem_dq_in,
    // Startup primitive side, used only with the startup option
    output logic [STARTUP_DQ_WIDTH-1:0] startup_dq_out,
    output logic [STARTUP_DQ_WIDTH-1:0] startup_dq_oe,
    input wire logic [STARTUP_DQ_WIDTH-1:0] startup_dq_in,
    output logic startup_chip_enable_n
);

    // ------------------------------------------------------------------
    // Build-time widths
    // ------------------------------------------------------------------
    // Illegal settings are pulled to a legal value: host data to 32 with SYNC_BURST, else above 32 bits to 64 and the rest to 32; identifier width into 0 to 16.
    localparam int HOST_WIDTH = SYNC_BURST ? SYNC_BURST_DATA_WIDTH
        : ((HOST_DATA_WIDTH > 32) ? 64 : 32);
    localparam int ID_USED = (ID_WIDTH > MAX_ID_WIDTH) ? MAX_ID_WIDTH
        : ((ID_WIDTH < 0) ? 0 : ID_WIDTH);
    localparam int LANES = MEM_WIDTH / 8;
    localparam logic [63:0] HOST_MASK = (HOST_WIDTH == 64) ? 64'hffff_ffff_ffff_ffff
        : 64'h0000_0000_ffff_ffff;
    localparam logic [16:0] ID_LIMIT = 17'h1_0000 >> (MAX_ID_WIDTH - ID_USED);
    localparam logic [15:0] ID_MASK = 16'(ID_LIMIT - 17'h1);
    localparam logic [MEM_WIDTH-1:0] STARTUP_MASK = MEM_WIDTH'(8'h0f);

    function automatic memory_kind_type kind_of(input logic [1:0] bank);
        kind_of = memory_kind_type'(BANK_KINDS[bank*KIND_WIDTH +: KIND_WIDTH]);
    endfunction : kind_of
    function automatic logic is_flash(input memory_kind_type kind);
        is_flash = (kind == KIND_LINEAR_FLASH) || (kind == KIND_PAGE_FLASH)
            || (kind == KIND_BURST_FLASH);
    endfunction : is_flash

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    logic [MEM_WIDTH-1:0] dq_merged;
    logic [MEM_WIDTH-1:0] dq_meta;
    logic [MEM_WIDTH-1:0] dq_sync;
    logic wait_meta;
    logic wait_sync;
    assign dq_merged = USE_STARTUP
        ? ((mem_dq_in & ~STARTUP_MASK) | MEM_WIDTH'(startup_dq_in)) : mem_dq_in;
    always_ff @(posedge clock)
    begin
        dq_meta <= dq_merged;
        dq_sync <= dq_meta;
        wait_meta <= mem_wait;
        wait_sync <= wait_meta;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] control;
    logic [TIMING_WIDTH-1:0] bank_timing [MAX_BANKS];
    logic last_error;
    logic [1:0] last_bank;
    sequence_state_type state;
    sequence_state_type next_state;

    wire apb_access = psel && penable && !pready;
    wire apb_commit = psel && penable && pready;
    wire [11:0] timing_span = paddr - TIMING_BASE_OFFSET;
    wire timing_hit = (paddr >= TIMING_BASE_OFFSET) && (paddr[1:0] == 2'h0)
        && (timing_span < 12'(BANKS) * TIMING_STRIDE);
    wire [1:0] timing_index = timing_span[3:2];
    wire control_hit = (paddr == CONTROL_OFFSET);
    wire status_hit = (paddr == STATUS_OFFSET);
    wire mapped = control_hit || status_hit || timing_hit;
    wire [SHIFT_WIDTH-1:0] address_shift = control[CTRL_SHIFT_LSB +: SHIFT_WIDTH];
    logic [31:0] read_value;
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (control_hit)
            read_value = control;
        else if (status_hit)
        begin
            read_value[STATUS_BUSY_BIT] = (state != ST_IDLE);
            read_value[STATUS_ERROR_BIT] = last_error;
            read_value[STATUS_BANK_LSB +: 2] = last_bank;
        end
        else if (timing_hit)
            read_value = 32'(bank_timing[timing_index]);
    end

    // The answer comes one cycle into the access phase; writes land with it.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_access;
            prdata <= (apb_access && !pwrite) ? read_value : 32'h0000_0000;
            pslverr <= apb_access && !mapped;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            control <= CONTROL_RESET;
        else if (apb_commit && pwrite && control_hit)
            control <= pwdata & CONTROL_MASK;
    end

    genvar t;
    generate
        for (t = 0; t < MAX_BANKS; t++)
        begin : timing_reg
            always_ff @(posedge clock)
            begin
                if (!resetn)
                    bank_timing[t] <= TIMING_RESET;
                else if (apb_commit && pwrite && timing_hit && timing_index == 2'(t))
                    bank_timing[t] <= pwdata[TIMING_WIDTH-1:0];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Request capture and bank decode
    // ------------------------------------------------------------------
    host_request_type held;
    logic [MAX_BANKS-1:0] bank_hit;
    logic [1:0] bank_index;
    logic any_hit;
    logic [1:0] current_bank;
    logic [MAX_BANKS-1:0] current_hit;
    logic [TIMING_WIDTH-1:0] hold_count;

    bank_window_decoder #(
        .BANKS(BANKS),
        .BANK_BASE(BANK_BASE),
        .BANK_HIGH(BANK_HIGH)
    ) decoder (
        .address(host_request.address),
        .bank_hit(bank_hit),
        .bank_index(bank_index),
        .any_hit(any_hit)
    );

    wire take = host_valid && host_ready;
    wire memory_kind_type kind = kind_of(current_bank);
    wire hold_done = (hold_count == '0) && !wait_sync;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (take && any_hit) next_state = ST_ADDRESS;
            ST_ADDRESS: next_state = ST_CHIP;
            ST_CHIP: next_state = ST_STROBE;
            ST_STROBE: if (hold_done) next_state = ST_RELEASE;
            ST_RELEASE: next_state = ST_FINISH;
            ST_FINISH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            host_ready <= 1'b1;
            held <= '0;
            current_bank <= 2'h0;
            current_hit <= '0;
            last_error <= 1'b0;
            last_bank <= 2'h0;
            hold_count <= '0;
        end
        else
        begin
            state <= next_state;
            host_ready <= (next_state == ST_IDLE);
            if (take)
            begin
                held <= host_request;
                current_bank <= bank_index;
                current_hit <= bank_hit;
                last_error <= !any_hit;
                last_bank <= bank_index;
            end
            if (state == ST_CHIP)
                hold_count <= bank_timing[current_bank];
            else if (state == ST_STROBE && hold_count != '0)
                hold_count <= hold_count - TIMING_WIDTH'(1);
        end
    end

    // ------------------------------------------------------------------
    // Memory pin sequencing
    // ------------------------------------------------------------------
    // Address leads chip enable by a cycle and chip enable leads the strobe by
    // a cycle; on release the order reverses, so every edge is one cycle apart.
    wire chip_on = (next_state == ST_CHIP) || (next_state == ST_STROBE)
        || (next_state == ST_RELEASE);
    wire [LANES-1:0] lane_strobe = LANES'(held.strobe);
    wire [MEM_WIDTH-1:0] write_word = MEM_WIDTH'(held.write_data & HOST_MASK);
    wire psram_bank = (kind == KIND_PSRAM);
    logic [MAX_BANKS-1:0] chip_n;
    logic [MEM_WIDTH-1:0] dq_drive;
    logic [MEM_WIDTH-1:0] dq_enable;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            mem_address <= '0;
            chip_n <= '1;
            memory_output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            lane_write_enable_n <= '1;
            byte_enable_n <= '1;
            memory_reset_powerdown_n <= 1'b0;
            config_reg_enable <= 1'b0;
            dq_drive <= '0;
            dq_enable <= '0;
        end
        else
        begin
            memory_reset_powerdown_n <= !control[CTRL_HOLD_RESET_BIT];
            config_reg_enable <= control[CTRL_CRE_BIT] && psram_bank;
            if (take && any_hit)
                mem_address <= MEM_ADDR_WIDTH'(host_request.address >> address_shift);
            chip_n <= chip_on ? ~current_hit : '1;
            memory_output_enable_n <= !(next_state == ST_STROBE && !held.write);
            write_enable_n <= !(next_state == ST_STROBE && held.write && !is_flash(kind));
            lane_write_enable_n <= (next_state == ST_STROBE && held.write && is_flash(kind))
                ? ~lane_strobe : '1;
            byte_enable_n <= (chip_on && !is_flash(kind))
                ? (held.write ? ~lane_strobe : '0) : '1;
            dq_drive <= write_word;
            dq_enable <= (held.write && (chip_on || next_state == ST_FINISH)) ? '1 : '0;
        end
    end

    // Writes keep the data driven through the chip-enable release for hold time.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            answer_valid <= 1'b0;
            answer <= '0;
        end
        else
        begin
            answer_valid <= (state == ST_FINISH) || (take && !any_hit);
            if (take && !any_hit)
            begin
                answer.error <= 1'b1;
                answer.read_data <= 64'h0;
                answer.id <= host_request.id & ID_MASK;
            end
            else if (state == ST_RELEASE)
            begin
                answer.error <= 1'b0;
                answer.read_data <= held.write ? 64'h0 : (64'(dq_sync) & HOST_MASK);
                answer.id <= held.id & ID_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Startup primitive routing
    // ------------------------------------------------------------------
    assign mem_dq_out = USE_STARTUP ? (dq_drive & ~STARTUP_MASK) : dq_drive;
    assign mem_dq_oe = USE_STARTUP ? (dq_enable & ~STARTUP_MASK) : dq_enable;
    assign startup_dq_out = USE_STARTUP ? dq_drive[STARTUP_DQ_WIDTH-1:0] : '0;
    assign startup_dq_oe = USE_STARTUP ? dq_enable[STARTUP_DQ_WIDTH-1:0] : '0;
    assign startup_chip_enable_n = USE_STARTUP ? chip_n[0] : 1'b1;
    assign mem_chip_enable_n = USE_STARTUP ? (chip_n | MAX_BANKS'(1)) : chip_n;

endmodule : external_memory_controller

/* File: tb/memory_controller_assertions.sv */
module emc_checker
    import memory_controller_pkg::*;
#(
    parameter int MEM_WIDTH = 32,
    parameter int MEM_ADDR_WIDTH = 32,
    parameter bit USE_STARTUP = 1'b0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Handshakes
    input wire logic pready,
    input wire logic host_ready,
    input wire logic answer_valid,
    // Memory pins
    input wire logic [MEM_ADDR_WIDTH-1:0] mem_address,
    input wire logic [MAX_BANKS-1:0] mem_chip_enable_n,
    input wire logic memory_output_enable_n,
    input wire logic write_enable_n,
    input wire logic [MEM_WIDTH/8-1:0] byte_enable_n,
    input wire logic [MEM_WIDTH-1:0] mem_dq_oe,
    input wire logic [STARTUP_DQ_WIDTH-1:0] startup_dq_oe,
    input wire logic startup_chip_enable_n
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic chip_on;
    wire logic strobe_fell;
    assign chip_on = ~&mem_chip_enable_n;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // Strobe edges are sampled only in the assertions, never in the wires above.
    a_chip_onehot: assert property ($onehot0(~mem_chip_enable_n))
        else $error("more than one chip enable low");
    a_addr_before_chip: assert property ($rose(chip_on) |-> $stable(mem_address))
        else $error("address moved with chip enable");
    a_chip_before_strobe: assert property ($rose(chip_on) |->
        memory_output_enable_n && write_enable_n)
        else $error("strobe fell with chip enable");
    a_strobe_after_chip: assert property ($fell(write_enable_n) || $fell(memory_output_enable_n)
        |-> $past(chip_on))
        else $error("strobe without a chip enable cycle before");
    a_release_order: assert property ($fell(chip_on) |->
        $past(memory_output_enable_n) && $past(write_enable_n))
        else $error("chip enable rose with strobe");
    a_addr_hold: assert property (chip_on || $fell(chip_on) |-> $stable(mem_address))
        else $error("address moved during access");
    a_read_lanes: assert property (!memory_output_enable_n |-> byte_enable_n == '0)
        else $error("byte enables not all low on read");
    a_write_drive: assert property (!write_enable_n |-> &mem_dq_oe)
        else $error("data not driven during write strobe");
    a_startup_idle: assert property (!USE_STARTUP |->
        startup_chip_enable_n && startup_dq_oe == '0)
        else $error("startup port active while option off");
    a_busy_refuse: assert property (chip_on |-> !host_ready)
        else $error("host ready during access");
    a_answer_pulse: assert property (answer_valid |=> !answer_valid)
        else $error("answer valid longer than one cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    c_write: cover property ($fell(write_enable_n));
    c_read: cover property ($fell(memory_output_enable_n));
    c_apb: cover property (pready);
endmodule : emc_checker

bind external_memory_controller emc_checker #(.MEM_WIDTH(MEM_WIDTH),
    .MEM_ADDR_WIDTH(MEM_ADDR_WIDTH), .USE_STARTUP(USE_STARTUP)) i_checker (
    .clock(clock), .resetn(resetn), .pready(pready), .host_ready(host_ready),
    .answer_valid(answer_valid), .mem_address(mem_address),
    .mem_chip_enable_n(mem_chip_enable_n), .memory_output_enable_n(memory_output_enable_n),
    .write_enable_n(write_enable_n), .byte_enable_n(byte_enable_n), .mem_dq_oe(mem_dq_oe),
    .startup_dq_oe(startup_dq_oe), .startup_chip_enable_n(startup_chip_enable_n));

/* File: tb/memory_partner.sv */
module memory_partner
    import memory_controller_pkg::*;
#(
    parameter int MEM_WIDTH = 16
)
(
    // Bench side
    input wire logic clock,
    input wire logic slow,
    // Memory pins
    input wire logic [31:0] mem_address,
    input wire logic [MAX_BANKS-1:0] mem_chip_enable_n,
    input wire logic memory_output_enable_n,
    input wire logic write_enable_n,
    input wire logic [MEM_WIDTH/8-1:0] byte_enable_n,
    input wire logic [MEM_WIDTH-1:0] mem_dq_out,
    output logic [MEM_WIDTH-1:0] mem_dq_in,
    output logic mem_wait
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [MEM_WIDTH-1:0] store [logic [35:0]];
    logic [MEM_WIDTH-1:0] word;
    logic [35:0] key;
    int held = 0;
    assign key = {~mem_chip_enable_n, mem_address};
    // A slow part holds wait for three cycles at the start of every access.
    assign mem_wait = slow && held < 3 && key[35:32] != 4'h0;
    initial mem_dq_in = '0;
    always @(posedge clock)
    begin
        held <= (key[35:32] == 4'h0) ? 0 : held + 1;
        if (key[35:32] != 4'h0 && !write_enable_n)
        begin
            word = store.exists(key) ? store[key] : '0;
            for (int b = 0; b < MEM_WIDTH/8; b++)
                if (!byte_enable_n[b])
                    word[b*8+:8] = mem_dq_out[b*8+:8];
            store[key] = word;
        end
        // Released data lines toggle so a stale sample cannot pass.
        if (key[35:32] != 4'h0 && !memory_output_enable_n)
            mem_dq_in <= store.exists(key) ? store[key] : '0;
        else
            mem_dq_in <= ~mem_dq_in;
    end
endmodule : memory_partner

/* File: tb/external_memory_controller_tb.sv */
module external_memory_controller_tb
    import memory_controller_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, host_valid = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, mem_address, q, a, c;
    logic pready, pslverr, host_ready, answer_valid, memory_output_enable_n, write_enable_n;
    logic memory_reset_powerdown_n, config_reg_enable, mem_wait, startup_chip_enable_n, e;
    host_request_type host_request = '0;
    host_response_type answer, r;
    logic [3:0] mem_chip_enable_n, startup_dq_out, startup_dq_oe, seen_bank;
    logic [1:0] lane_write_enable_n, byte_enable_n, seen_ben, sh;
    logic [15:0] mem_dq_out, mem_dq_oe, mem_dq_in, d, old;
    logic [7:0] s;
    logic [31:0] seen_addr;
    logic seen_cre;
    logic [15:0] model [logic [31:0]];
    int err_count = 0, samples_checked = 0, seed = 32'hec51, bank;
    external_memory_controller #(.MEM_WIDTH(16), .BANKS(2), .BANK_KINDS(12'h00c)) i_dut (
        .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .host_valid, .host_request, .host_ready, .answer_valid, .answer,
        .mem_address, .mem_chip_enable_n, .memory_output_enable_n, .write_enable_n,
        .lane_write_enable_n, .byte_enable_n, .memory_reset_powerdown_n, .config_reg_enable,
        .mem_wait, .mem_dq_out, .mem_dq_oe, .mem_dq_in, .startup_dq_out, .startup_dq_oe,
        .startup_dq_in(4'h0), .startup_chip_enable_n);
    memory_partner #(.MEM_WIDTH(16)) i_partner (.clock, .slow, .mem_address,
        .mem_chip_enable_n, .memory_output_enable_n, .write_enable_n, .byte_enable_n,
        .mem_dq_out, .mem_dq_in, .mem_wait);
    always #50 clock = ~clock;
    always @(posedge clock)
    begin
        if (host_valid && host_ready)
            seen_bank <= 4'h0;
        else if (mem_chip_enable_n != 4'hf)
        begin
            seen_bank <= ~mem_chip_enable_n;
            seen_addr <= mem_address;
            seen_cre <= config_reg_enable;
        end
        if (!write_enable_n)
            seen_ben <= byte_enable_n;
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_high(ref logic sig);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (sig !== 1'b1 && n < 200);
        if (n >= 200)
            err_count++;
    endtask : wait_high
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        wait_high(pready);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic access(input logic wr, input logic [31:0] ad, input logic [15:0] wd,
        input logic [7:0] st);
        host_valid <= 1'b1;
        host_request <= '{wr, ad, {48'h0, wd}, st, 16'h0005};
        wait_high(host_ready);
        host_valid <= 1'b0;
        wait_high(answer_valid);
        r = answer;
    endtask : access
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        #(40000 * 100);
        err_count++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        check("control reset", q, CONTROL_RESET);
        apb(1'b0, TIMING_BASE_OFFSET + TIMING_STRIDE, 32'h0);
        check("bank 1 timing", {e, q[7:0]}, {1'b0, TIMING_RESET});
        apb(1'b0, 12'(TIMING_BASE_OFFSET + 2 * TIMING_STRIDE), 32'h0);
        check("absent bank timing error", e, 1'b1);
        check("reset powerdown released", memory_reset_powerdown_n, 1'b1);
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            bank = i % 2;
            sh = 2'(i / 2);
            slow <= (i >= 4);
            apb(1'b1, CONTROL_OFFSET, {26'h0, 4'h4, sh});
            c = $random(seed) & 32'h000f_fffe;
            a = (32'(bank) << 28) | (c << sh);
            d = 16'($random(seed));
            s = (i == 3) ? 8'h02 : 8'h03;
            access(1'b1, a, d, s);
            check("write error", r.error, 1'b0);
            check("chip enable", seen_bank, 4'h1 << bank);
            check("memory address", seen_addr, a >> sh);
            check("config enable", seen_cre, bank == 0);
            check("write lanes", seen_ben, 2'(~s[1:0]));
            old = model.exists(a) ? model[a] : 16'h0;
            for (int b = 0; b < 2; b++)
                if (s[b])
                    old[b*8+:8] = d[b*8+:8];
            model[a] = old;
            access(1'b0, a, 16'h0, 8'h0);
            check("read data", r.read_data[15:0], model[a]);
            check("answer id", r.id[3:0], 4'h5);
            $display("access test %0d done", i);
        end
        access(1'b1, 32'h2000_0040, 16'h1234, 8'h03);
        check("unmapped error", r.error, 1'b1);
        check("unmapped chip enable", seen_bank, 4'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check("status unmapped", {e, q[STATUS_ERROR_BIT]}, 2'h1);
        $display("unmapped test done");
        complete_run();
    end
endmodule : external_memory_controller_tb
